// File: design/crs_core.v
// CPU register set with flag logic, interrupt entry and low-power states
//
// Contract
// RQ1: 8-bit accumulator holds operands and takes arithmetic and logic results.
// RQ2: 16-bit index from high and low bytes forms indexed operand addresses.
// RQ3: Reset presets the stack pointer to 00ff.
// RQ4: Stack low-byte preset forces low byte to ff, high byte kept.
// RQ5: Stack pointer decrements per push and increments per pull.
// RQ6: Stack-relative addressing adds the offset to the stack pointer.
// RQ7: Program counter steps per fetch; jumps and interrupts load it.
// RQ8: Reset loads the program counter from fffe (high) and ffff (low).
// RQ9: Flag bits 6 and 5 always read as one.
// RQ10: Overflow flag follows two's complement overflow of the result.
// RQ11: Half-carry is carry from bit 3 on adds; decimal adjust uses it.
// RQ12: Mask blocks maskable interrupts; entry sets it after stacking.
// RQ13: Interrupt entry does not stack the index high byte.
// RQ14: Return pulls the mask; reset sets it; unmask, wait and stop clear it.
// RQ15: With several requests pending the highest priority goes first.
// RQ16: Negative flag copies bit 7 of the result.
// RQ17: Zero flag is set for a 00 result, cleared otherwise.
// RQ18: Carry flag from bit 7 carry or borrow; shifts and rotates too.
// RQ19: Wait clears the mask and halts the CPU clock until interrupt.
// RQ20: Stop clears the mask, halts; restart waits the stabilisation delay.
// RQ21: Break loads the trap opcode and vector fffc or fefc in monitor.
// RQ22: Break starts at instruction end; return ends it once request drops.
// RQ23: Untouched flags keep their value; updates are seen next instruction.
`include "crs_defs.vh"

module crs_core #(
	parameter [12:0] STAB_LONG   = 13'd4096,
	parameter [12:0] STAB_SHORT  = 13'd32,
	parameter [7:0]  SWI_OPCODE  = 8'h00,
	parameter [15:0] IRQ_VEC_TOP = 16'hfffa
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        clk_en,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        cmd_valid,
	output wire        cmd_ready,
	input  wire [4:0]  cmd_code,
	input  wire [15:0] cmd_data,
	input  wire        pc_step,
	input  wire        insn_done,
	input  wire [3:0]  irq_pend,
	input  wire        break_req,
	input  wire        monitor_mode,
	output reg         vec_rd,
	output reg  [15:0] vec_addr,
	input  wire        vec_ack,
	input  wire [7:0]  vec_data,
	output reg         stk_we,
	output reg  [15:0] stk_addr,
	output reg  [7:0]  stk_wdata,
	output reg  [15:0] operand_addr,
	output reg  [7:0]  ins_reg,
	output reg         ins_load,
	output reg         in_break,
	output wire        cpu_run,
	output reg  [7:0]  accumulator,
	output reg  [15:0] index_pair,
	output reg  [15:0] stack_top_pointer,
	output reg  [15:0] instruction_pointer,
	output reg  [7:0]  flags_and_mask
);

localparam [2:0] ST_VEC_HI = 3'd0;
localparam [2:0] ST_VEC_LO = 3'd1;
localparam [2:0] ST_RUN    = 3'd2;
localparam [2:0] ST_STACK  = 3'd3;
localparam [2:0] ST_WAIT   = 3'd4;
localparam [2:0] ST_STOP   = 3'd5;
localparam [2:0] ST_RECOV  = 3'd6;

reg  [2:0]  state;
reg  [2:0]  stk_cnt;
reg  [12:0] stab_cnt;
reg  [15:0] vec_base;
reg         short_recover;
reg  [7:0]  next_acc;
reg  [7:0]  next_ccr;
reg  [8:0]  sum;
reg  [4:0]  nib;
reg  [7:0]  res;
reg  [7:0]  corr;
reg         cin;
reg         alu;
wire [7:0]  opnd;
wire        cmd_take;
wire        wr_take;
wire        brk_pend;
wire        irq_ok;
wire [15:0] irq_vec;

// Forces the two fixed flag bits to one
function [7:0] f_fix;
	input [7:0] v;
	begin
		f_fix = v | `CRS_FLAGS_ONES;
	end
endfunction

// Byte-lane merge of a 16-bit register
function [15:0] f_merge;
	input [15:0] old;
	input [31:0] d;
	input [3:0]  be;
	begin
		f_merge[7:0]  = be[0] ? d[7:0] : old[7:0];
		f_merge[15:8] = be[1] ? d[15:8] : old[15:8];
	end
endfunction

function f_mapped;
	input [7:0] a;
	begin
		f_mapped = (a[7:2] <= `CRS_OFF_STATUS >> 2);
	end
endfunction

// Lowest request index has the highest priority
function [1:0] f_prio;
	input [3:0] r;
	begin
		if (r[0])
			f_prio = 2'd0;
		else if (r[1])
			f_prio = 2'd1;
		else if (r[2])
			f_prio = 2'd2;
		else
			f_prio = 2'd3;
	end
endfunction

assign opnd     = cmd_data[7:0];
assign cmd_ready = clk_en & (state == ST_RUN);
assign cmd_take = cmd_valid & cmd_ready;
assign wr_take  = clk_en & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
assign s_axi_awready = wr_take;
assign s_axi_wready  = wr_take;
assign s_axi_arready = clk_en & ~s_axi_rvalid;
assign brk_pend = break_req & ~in_break;
assign irq_ok   = ~flags_and_mask[`CRS_I] & (|irq_pend); // RQ12
assign irq_vec  = IRQ_VEC_TOP - {13'h0000, f_prio(irq_pend), 1'b0}; // RQ15
assign cpu_run  = (state != ST_WAIT) & (state != ST_STOP) &
	(state != ST_RECOV);

// Result and flag calculation for accumulator operations
always @* begin
	next_acc = accumulator;
	next_ccr = flags_and_mask; // RQ23
	cin = 1'b0;
	sum = 9'h000;
	nib = 5'h00;
	corr = 8'h00;
	res = accumulator;
	alu = 1'b1;
	case (cmd_code)
	`CRS_CMD_ADD, `CRS_CMD_ADC: begin
		cin = (cmd_code == `CRS_CMD_ADC) & flags_and_mask[`CRS_C];
		sum = {1'b0, accumulator} + {1'b0, opnd} + {8'h00, cin};
		nib = {1'b0, accumulator[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
		res = sum[7:0];
		next_ccr[`CRS_H] = nib[4]; // RQ11
		next_ccr[`CRS_C] = sum[8]; // RQ18
		next_ccr[`CRS_V] = (accumulator[7] == opnd[7]) &
			(res[7] != accumulator[7]); // RQ10
	end
	`CRS_CMD_SUB, `CRS_CMD_SBC: begin
		cin = (cmd_code == `CRS_CMD_SBC) & flags_and_mask[`CRS_C];
		sum = {1'b0, accumulator} - {1'b0, opnd} - {8'h00, cin};
		res = sum[7:0];
		next_ccr[`CRS_C] = sum[8]; // RQ18
		next_ccr[`CRS_V] = (accumulator[7] != opnd[7]) &
			(res[7] != accumulator[7]); // RQ10
	end
	`CRS_CMD_AND: begin
		res = accumulator & opnd;
		next_ccr[`CRS_V] = 1'b0;
	end
	`CRS_CMD_ORA: begin
		res = accumulator | opnd;
		next_ccr[`CRS_V] = 1'b0;
	end
	`CRS_CMD_EOR: begin
		res = accumulator ^ opnd;
		next_ccr[`CRS_V] = 1'b0;
	end
	`CRS_CMD_LDA: begin
		res = opnd;
		next_ccr[`CRS_V] = 1'b0;
	end
	`CRS_CMD_ASL: begin
		res = {accumulator[6:0], 1'b0};
		next_ccr[`CRS_C] = accumulator[7]; // RQ18
		next_ccr[`CRS_V] = res[7] ^ accumulator[7]; // RQ10
	end
	`CRS_CMD_LSR: begin
		res = {1'b0, accumulator[7:1]};
		next_ccr[`CRS_C] = accumulator[0]; // RQ18
		next_ccr[`CRS_V] = accumulator[0]; // RQ10
	end
	`CRS_CMD_ROL: begin
		res = {accumulator[6:0], flags_and_mask[`CRS_C]};
		next_ccr[`CRS_C] = accumulator[7]; // RQ18
		next_ccr[`CRS_V] = res[7] ^ accumulator[7]; // RQ10
	end
	`CRS_CMD_ROR: begin
		res = {flags_and_mask[`CRS_C], accumulator[7:1]};
		next_ccr[`CRS_C] = accumulator[0]; // RQ18
		next_ccr[`CRS_V] = res[7] ^ accumulator[0]; // RQ10
	end
	`CRS_CMD_DAA: begin
		if (flags_and_mask[`CRS_H] | (accumulator[3:0] > 4'h9))
			corr[3:0] = 4'h6; // RQ11
		if (flags_and_mask[`CRS_C] | (accumulator > 8'h99))
			corr[7:4] = 4'h6;
		res = accumulator + corr;
		next_ccr[`CRS_C] = flags_and_mask[`CRS_C] |
			(accumulator > 8'h99); // RQ11
	end
	default: begin
		alu = 1'b0; // RQ23
	end
	endcase
	if (alu) begin
		next_acc = res; // RQ1
		next_ccr[`CRS_N] = res[7]; // RQ16
		next_ccr[`CRS_Z] = (res == 8'h00); // RQ17
	end
end

always @(posedge ref_clk) begin
	if (rst) begin
		accumulator         <= 8'h00;
		index_pair          <= 16'h0000;
		stack_top_pointer   <= `CRS_SP_RESET; // RQ3
		instruction_pointer <= 16'h0000;
		flags_and_mask      <= `CRS_FLAGS_RESET; // RQ14
		state               <= ST_VEC_HI;
		vec_rd              <= 1'b1; // RQ8
		vec_addr            <= `CRS_VEC_RESET; // RQ8
		vec_base            <= `CRS_VEC_RESET;
		stk_cnt             <= 3'd0;
		stab_cnt            <= 13'd0;
		stk_we              <= 1'b0;
		stk_addr            <= 16'h0000;
		stk_wdata           <= 8'h00;
		operand_addr        <= 16'h0000;
		ins_reg             <= 8'h00;
		ins_load            <= 1'b0;
		in_break            <= 1'b0;
		short_recover       <= 1'b0;
		s_axi_bvalid        <= 1'b0;
		s_axi_bresp         <= `CRS_RESP_OKAY;
		s_axi_rvalid        <= 1'b0;
		s_axi_rresp         <= `CRS_RESP_OKAY;
		s_axi_rdata         <= 32'h00000000;
	end else if (clk_en) begin
		stk_we   <= 1'b0;
		ins_load <= 1'b0;
		if (s_axi_bvalid & s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (s_axi_rvalid & s_axi_rready)
			s_axi_rvalid <= 1'b0;
		if (wr_take) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= f_mapped(s_axi_awaddr) ?
				`CRS_RESP_OKAY : `CRS_RESP_SLVERR;
			case ({s_axi_awaddr[7:2], 2'b00})
			`CRS_OFF_ACC:
				if (s_axi_wstrb[0])
					accumulator <= s_axi_wdata[7:0];
			`CRS_OFF_INDEX:
				index_pair <= f_merge(index_pair, s_axi_wdata,
					s_axi_wstrb);
			`CRS_OFF_STACK:
				stack_top_pointer <= f_merge(stack_top_pointer,
					s_axi_wdata, s_axi_wstrb);
			`CRS_OFF_IP:
				instruction_pointer <= f_merge(instruction_pointer,
					s_axi_wdata, s_axi_wstrb);
			`CRS_OFF_FLAGS:
				if (s_axi_wstrb[0])
					flags_and_mask <= f_fix(s_axi_wdata[7:0]); // RQ9
			`CRS_OFF_CTRL:
				if (s_axi_wstrb[0])
					short_recover <= s_axi_wdata[`CRS_CTRL_SHORT];
			default: begin
			end
			endcase
		end
		if (s_axi_arready & s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= f_mapped(s_axi_araddr) ?
				`CRS_RESP_OKAY : `CRS_RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'b00})
			`CRS_OFF_ACC:    s_axi_rdata <= {24'h000000, accumulator};
			`CRS_OFF_INDEX:  s_axi_rdata <= {16'h0000, index_pair};
			`CRS_OFF_STACK:  s_axi_rdata <= {16'h0000, stack_top_pointer};
			`CRS_OFF_IP:     s_axi_rdata <= {16'h0000, instruction_pointer};
			`CRS_OFF_FLAGS:  s_axi_rdata <= {24'h000000, flags_and_mask};
			`CRS_OFF_CTRL:   s_axi_rdata <= {31'h00000000, short_recover};
			`CRS_OFF_STATUS: s_axi_rdata <= {25'h0000000, state, 2'b00,
				in_break, cpu_run};
			default:         s_axi_rdata <= 32'h00000000;
			endcase
		end
		case (state)
		ST_VEC_HI: begin
			if (vec_ack) begin
				instruction_pointer[15:8] <= vec_data; // RQ8
				vec_addr <= vec_base + 16'h0001;
				state    <= ST_VEC_LO;
			end
		end
		ST_VEC_LO: begin
			if (vec_ack) begin
				instruction_pointer[7:0] <= vec_data; // RQ8
				vec_rd <= 1'b0;
				state  <= ST_RUN;
			end
		end
		ST_RUN: begin
			if (pc_step)
				instruction_pointer <= instruction_pointer + 16'h0001; // RQ7
			if (cmd_take) begin
				accumulator    <= next_acc; // RQ1
				flags_and_mask <= f_fix(next_ccr); // RQ23
				case (cmd_code)
				`CRS_CMD_LDHX: index_pair <= cmd_data; // RQ2
				`CRS_CMD_LDSP: stack_top_pointer <= cmd_data;
				`CRS_CMD_TAP:  flags_and_mask <= f_fix(opnd); // RQ9
				`CRS_CMD_CLI:  flags_and_mask[`CRS_I] <= 1'b0; // RQ14
				`CRS_CMD_SEI:  flags_and_mask[`CRS_I] <= 1'b1;
				`CRS_CMD_RSP:  stack_top_pointer[7:0] <= `CRS_SP_LOW; // RQ4
				`CRS_CMD_PUSH:
					stack_top_pointer <= stack_top_pointer - 16'h0001; // RQ5
				`CRS_CMD_PULL: begin
					stack_top_pointer <= stack_top_pointer + 16'h0001; // RQ5
					case (cmd_data[10:8])
					`CRS_PUL_ACC:   accumulator <= opnd;
					`CRS_PUL_X:     index_pair[7:0] <= opnd;
					`CRS_PUL_H:     index_pair[15:8] <= opnd;
					`CRS_PUL_FLAGS: flags_and_mask <= f_fix(opnd); // RQ14
					`CRS_PUL_IPL:   instruction_pointer[7:0] <= opnd;
					`CRS_PUL_IPH:   instruction_pointer[15:8] <= opnd;
					default: begin
					end
					endcase
				end
				`CRS_CMD_JUMP: instruction_pointer <= cmd_data; // RQ7
				`CRS_CMD_EA_IX: operand_addr <= index_pair + cmd_data; // RQ2
				`CRS_CMD_EA_SP:
					operand_addr <= stack_top_pointer + cmd_data; // RQ6
				`CRS_CMD_WAIT: begin
					flags_and_mask[`CRS_I] <= 1'b0; // RQ19
					state <= ST_WAIT;
				end
				`CRS_CMD_STOP: begin
					flags_and_mask[`CRS_I] <= 1'b0; // RQ20
					state <= ST_STOP;
				end
				`CRS_CMD_RTI:
					if (~break_req)
						in_break <= 1'b0; // RQ22
				default: begin
				end
				endcase
			end
			if (insn_done & brk_pend) begin
				in_break <= 1'b1; // RQ22
				ins_reg  <= SWI_OPCODE; // RQ21
				ins_load <= 1'b1;
				vec_base <= monitor_mode ? `CRS_VEC_BRKMON :
					`CRS_VEC_BREAK; // RQ21
				stk_cnt  <= 3'd0;
				state    <= ST_STACK;
			end else if (insn_done & irq_ok) begin
				vec_base <= irq_vec; // RQ15
				stk_cnt  <= 3'd0;
				state    <= ST_STACK;
			end
		end
		ST_STACK: begin
			stk_we    <= 1'b1;
			stk_addr  <= stack_top_pointer;
			stack_top_pointer <= stack_top_pointer - 16'h0001; // RQ5
			stk_cnt   <= stk_cnt + 3'd1;
			case (stk_cnt)
			3'd0:    stk_wdata <= instruction_pointer[7:0];
			3'd1:    stk_wdata <= instruction_pointer[15:8];
			3'd2:    stk_wdata <= index_pair[7:0]; // RQ13
			3'd3:    stk_wdata <= accumulator;
			default: stk_wdata <= flags_and_mask;
			endcase
			if (stk_cnt == 3'd4) begin
				flags_and_mask[`CRS_I] <= 1'b1; // RQ12
				vec_rd   <= 1'b1;
				vec_addr <= vec_base;
				state    <= ST_VEC_HI;
			end
		end
		ST_WAIT: begin
			if (|irq_pend) begin
				vec_base <= irq_vec; // RQ19
				stk_cnt  <= 3'd0;
				state    <= ST_STACK;
			end
		end
		ST_STOP: begin
			if (|irq_pend) begin
				vec_base <= irq_vec;
				stab_cnt <= (short_recover ? STAB_SHORT : STAB_LONG) -
					13'd1; // RQ20
				state    <= ST_RECOV;
			end
		end
		ST_RECOV: begin
			if (stab_cnt == 13'd0) begin
				stk_cnt <= 3'd0;
				state   <= ST_STACK; // RQ20
			end else begin
				stab_cnt <= stab_cnt - 13'd1;
			end
		end
		default: state <= ST_RUN;
		endcase
	end
end

endmodule

// File: design/crs_defs.vh
// Offsets, field positions, codes and reset values of the CPU register set
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH

// Register offsets, byte addresses on the register bus
`define CRS_OFF_ACC     8'h00
`define CRS_OFF_INDEX   8'h04
`define CRS_OFF_STACK   8'h08
`define CRS_OFF_IP      8'h0c
`define CRS_OFF_FLAGS   8'h10
`define CRS_OFF_CTRL    8'h14
`define CRS_OFF_STATUS  8'h18

// Flag positions in flags_and_mask
`define CRS_V           7
`define CRS_H           4
`define CRS_I           3
`define CRS_N           2
`define CRS_Z           1
`define CRS_C           0
`define CRS_FLAGS_ONES  8'h60
`define CRS_FLAGS_RESET 8'h68

// Reset values and vectors
`define CRS_SP_RESET    16'h00ff
`define CRS_SP_LOW      8'hff
`define CRS_VEC_RESET   16'hfffe
`define CRS_VEC_BREAK   16'hfffc
`define CRS_VEC_BRKMON  16'hfefc

// Control and status fields
`define CRS_CTRL_SHORT  0
`define CRS_ST_RUN      0
`define CRS_ST_BREAK    1

// Commands from the execution unit
`define CRS_CMD_NOP     5'h00
`define CRS_CMD_ADD     5'h01
`define CRS_CMD_ADC     5'h02
`define CRS_CMD_SUB     5'h03
`define CRS_CMD_SBC     5'h04
`define CRS_CMD_AND     5'h05
`define CRS_CMD_ORA     5'h06
`define CRS_CMD_EOR     5'h07
`define CRS_CMD_LDA     5'h08
`define CRS_CMD_ASL     5'h09
`define CRS_CMD_LSR     5'h0a
`define CRS_CMD_ROL     5'h0b
`define CRS_CMD_ROR     5'h0c
`define CRS_CMD_DAA     5'h0d
`define CRS_CMD_LDHX    5'h0e
`define CRS_CMD_LDSP    5'h0f
`define CRS_CMD_TAP     5'h10
`define CRS_CMD_CLI     5'h11
`define CRS_CMD_SEI     5'h12
`define CRS_CMD_RSP     5'h13
`define CRS_CMD_PUSH    5'h14
`define CRS_CMD_PULL    5'h15
`define CRS_CMD_JUMP    5'h16
`define CRS_CMD_EA_IX   5'h17
`define CRS_CMD_EA_SP   5'h18
`define CRS_CMD_WAIT    5'h19
`define CRS_CMD_STOP    5'h1a
`define CRS_CMD_RTI     5'h1b

// Pull targets in cmd_data[10:8]
`define CRS_PUL_ACC     3'h0
`define CRS_PUL_X       3'h1
`define CRS_PUL_H       3'h2
`define CRS_PUL_FLAGS   3'h3
`define CRS_PUL_IPL     3'h4
`define CRS_PUL_IPH     3'h5

`define CRS_RESP_OKAY   2'h0
`define CRS_RESP_SLVERR 2'h2

`endif

// File: dv/crs_core_sva.sv
// Port assertions for the CPU register set
module crs_core_sva (
	input logic        ref_clk,
	input logic        rst,
	input logic        cmd_valid,
	input logic        cmd_ready,
	input logic [4:0]  cmd_code,
	input logic [15:0] cmd_data,
	input logic        pc_step,
	input logic        insn_done,
	input logic        monitor_mode,
	input logic        vec_rd,
	input logic [15:0] vec_addr,
	input logic        stk_we,
	input logic        in_break,
	input logic        cpu_run,
	input logic [15:0] stack_top_pointer,
	input logic [15:0] instruction_pointer,
	input logic [7:0]  flags_and_mask
);
	timeunit 1ns;
	timeprecision 1ps;
	wire       go = cmd_valid && cmd_ready;
	wire [7:0] sp_hi = stack_top_pointer[15:8];
	wire [7:0] opnd = cmd_data[7:0];
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	fixed_ones_a: assert property (flags_and_mask[6:5] == 2'b11)
		else $error("flag bits 6 and 5 not one");
	reset_vals_a: assert property ($fell(rst) |->
		stack_top_pointer == 16'h00ff && flags_and_mask[3] && vec_rd &&
		vec_addr == 16'hfffe)
		else $error("reset presets wrong");
	rsp_low_a: assert property (go && cmd_code == 5'h13 |=>
		stack_top_pointer == {$past(sp_hi), 8'hff})
		else $error("stack low preset wrong");
	push_dec_a: assert property (go && cmd_code == 5'h14 |=>
		stack_top_pointer == $past(stack_top_pointer) - 16'h0001)
		else $error("push did not decrement");
	pull_inc_a: assert property (go && cmd_code == 5'h15 |=>
		stack_top_pointer == $past(stack_top_pointer) + 16'h0001)
		else $error("pull did not increment");
	load_flags_a: assert property (go && cmd_code == 5'h08 |=>
		flags_and_mask[2:1] == {$past(opnd) >= 8'h80, $past(opnd) == 8'h00})
		else $error("load flags wrong");
	wait_mask_a: assert property (go && cmd_code == 5'h19 |=>
		!flags_and_mask[3] && !cpu_run)
		else $error("wait entry wrong");
	mask_vec_a: assert property ($rose(vec_rd) |-> flags_and_mask[3])
		else $error("vector fetched with mask clear");
	stack_five_a: assert property ($rose(stk_we) |->
		stk_we [*5] ##1 !stk_we)
		else $error("stacking not five bytes");
	break_vec_a: assert property ($rose(in_break) |-> ##[1:8]
		vec_rd && vec_addr == (monitor_mode ? 16'hfefc : 16'hfffc))
		else $error("break vector wrong");
	pc_step_a: assert property (cmd_ready && pc_step && !cmd_valid &&
		!insn_done |=> instruction_pointer ==
		$past(instruction_pointer) + 16'h0001)
		else $error("program counter did not step");
endmodule

bind crs_core crs_core_sva u_sva (.*);

// File: dv/tb.sv
// Self-checking bench for the CPU register set
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 0, rst = 1, clk_en = 1;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, cmd_valid = 0;
	logic        pc_step = 0, insn_done = 0, break_req = 0;
	logic        monitor_mode = 0, vec_ack = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, vec_data = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0]  s_axi_wstrb = 0, irq_pend = 0;
	logic [4:0]  cmd_code = 0;
	logic [15:0] cmd_data = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire         s_axi_rvalid, cmd_ready, vec_rd, stk_we, ins_load;
	wire         in_break, cpu_run;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [15:0]  vec_addr, stk_addr, operand_addr, index_pair;
	wire [15:0]  stack_top_pointer, instruction_pointer;
	wire [7:0]   stk_wdata, ins_reg, accumulator, flags_and_mask;
	int          bad_count = 0, samples_checked = 0, loads = 0;
	logic [23:0] stq[$];
	logic [31:0] rv;
	logic [1:0]  rr;

	crs_core #(.STAB_LONG(13'd8), .STAB_SHORT(13'd4),
		.SWI_OPCODE(8'hc5)) dut (.*);

	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (stk_we)
			stq.push_back({stk_addr, stk_wdata});
		if (ins_load)
			loads++;
	end

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cmd(logic [4:0] c, logic [15:0] d);
		@(posedge ref_clk);
		cmd_valid <= 1;
		cmd_code <= c;
		cmd_data <= d;
		@(negedge ref_clk);
		while (!cmd_ready)
			@(negedge ref_clk);
		@(posedge ref_clk);
		cmd_valid <= 0;
		#1;
	endtask

	// One-cycle end of instruction with the given requests pending
	task automatic done_pulse(logic [3:0] q);
		@(posedge ref_clk);
		insn_done <= 1;
		irq_pend <= q;
		@(posedge ref_clk);
		insn_done <= 0;
		irq_pend <= 0;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		@(negedge ref_clk);
		while (!(s_axi_awready && s_axi_wready))
			@(negedge ref_clk);
		@(posedge ref_clk);
		{s_axi_awvalid, s_axi_wvalid} <= 2'b00;
		@(negedge ref_clk);
		while (!s_axi_bvalid)
			@(negedge ref_clk);
		rr = s_axi_bresp;
		@(posedge ref_clk);
		s_axi_bready <= 0;
	endtask

	task automatic rd(logic [7:0] a);
		@(posedge ref_clk);
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		s_axi_araddr <= a;
		@(negedge ref_clk);
		while (!s_axi_arready)
			@(negedge ref_clk);
		@(posedge ref_clk);
		s_axi_arvalid <= 0;
		@(negedge ref_clk);
		while (!s_axi_rvalid)
			@(negedge ref_clk);
		{rv, rr} = {s_axi_rdata, s_axi_rresp};
		@(posedge ref_clk);
		s_axi_rready <= 0;
	endtask

	// Answers both vector bytes, high byte first
	task automatic vec(logic [15:0] at, logic [15:0] v);
		for (int i = 0; i < 2; i++) begin
			@(negedge ref_clk);
			while (!vec_rd)
				@(negedge ref_clk);
			chk("vec_addr", 16'(at + i), vec_addr);
			@(posedge ref_clk);
			vec_ack <= 1;
			vec_data <= i ? v[7:0] : v[15:8];
			@(posedge ref_clk);
			vec_ack <= 0;
		end
		#1;
	endtask

	task automatic t_reset;
		repeat (4) @(posedge ref_clk);
		rst <= 0;
		#1;
		chk("sp", 16'h00ff, stack_top_pointer);
		chk("flags", 8'h68, flags_and_mask);
		vec(16'hfffe, 16'h1234);
		chk("ip", 16'h1234, instruction_pointer);
		rd(8'h08);
		chk("sp reg", 32'h00ff, rv);
		rd(8'h1c);
		chk("unmapped resp", 2'h2, rr);
		chk("unmapped data", 0, rv);
		wr(8'h1c, 0);
		chk("unmapped wr resp", 2'h2, rr);
	endtask

	// Entries: command, operand, accumulator, flags
	task automatic t_alu;
		logic [31:0] tab[17] = '{
			32'h087f7f68,
			32'h010180fc,
			32'h018000eb,
			32'h0800006b,
			32'h02000168,
			32'h0302ff6d,
			32'h050f0f69,
			32'h0d007569,
			32'h0900eaec,
			32'h0b00d46d,
			32'h0c00eaec,
			32'h07ff1568,
			32'h0680956c,
			32'h0a004ae9,
			32'h044aff6d,
			32'h1003ff63,
			32'h1200ff6b
		};
		foreach (tab[i]) begin
			cmd(tab[i][28:24], {8'h00, tab[i][23:16]});
			chk("acc", tab[i][15:8], accumulator);
			chk("flags", tab[i][7:0], flags_and_mask);
		end
		wr(8'h10, 32'h0000_0008);
		chk("flags wr resp", 2'h0, rr);
		rd(8'h10);
		chk("flags reg", 32'h68, rv);
		rd(8'h00);
		chk("acc reg", 32'hff, rv);
	endtask

	task automatic t_stack;
		cmd(5'h0f, 16'h1234);
		cmd(5'h13, 0);
		chk("sp preset", 16'h12ff, stack_top_pointer);
		cmd(5'h14, 0);
		chk("sp push", 16'h12fe, stack_top_pointer);
		cmd(5'h15, 16'h005a);
		chk("sp pull", 16'h12ff, stack_top_pointer);
		chk("acc pull", 8'h5a, accumulator);
		cmd(5'h0e, 16'h0100);
		cmd(5'h17, 16'h0010);
		chk("ea index", 16'h0110, operand_addr);
		cmd(5'h18, 16'h0005);
		chk("ea stack", 16'h1304, operand_addr);
		cmd(5'h16, 16'h4000);
		@(posedge ref_clk);
		pc_step <= 1;
		repeat (3) @(posedge ref_clk);
		pc_step <= 0;
		#1;
		chk("ip step", 16'h4003, instruction_pointer);
	endtask

	task automatic t_irq;
		logic [7:0] sb[5] = '{8'h03, 8'h40, 8'h12, 8'h5a, 8'h60};
		cmd(5'h0e, 16'hab12);
		rd(8'h04);
		chk("index reg", 32'hab12, rv);
		stq.delete();
		done_pulse(4'b0110);
		repeat (3) @(posedge ref_clk);
		chk("masked irq", 0, stq.size());
		cmd(5'h11, 0);
		chk("mask clear", 8'h60, flags_and_mask);
		stq.delete();
		done_pulse(4'b0110);
		vec(16'hfff8, 16'h2000);
		chk("stack count", 5, stq.size());
		foreach (sb[i])
			chk("stack byte", {16'(16'h12ff - i), sb[i]}, stq[i]);
		chk("mask set", 8'h68, flags_and_mask);
		chk("ip vector", 16'h2000, instruction_pointer);
		cmd(5'h15, 16'h0360);
		chk("mask pulled", 8'h60, flags_and_mask);
		cmd(5'h1b, 0);
	endtask

	// Monitor mode first, then the normal break vector
	task automatic t_break;
		for (int m = 1; m >= 0; m--) begin
			@(posedge ref_clk);
			break_req <= 1;
			monitor_mode <= m[0];
			done_pulse(0);
			vec(m ? 16'hfefc : 16'hfffc, 16'h3000);
			chk("ins_reg", 8'hc5, ins_reg);
			chk("ins_load", 2 - m, loads);
			chk("in_break", 1, in_break);
			cmd(5'h1b, 0);
			chk("break held", 1, in_break);
			@(posedge ref_clk);
			break_req <= 0;
			cmd(5'h1b, 0);
			chk("break ended", 0, in_break);
		end
	endtask

	task automatic t_wait;
		cmd(5'h19, 0);
		chk("wait mask", 0, flags_and_mask[3]);
		chk("wait run", 0, cpu_run);
		stq.delete();
		@(posedge ref_clk);
		irq_pend <= 1;
		vec(16'hfffa, 16'h5000);
		@(posedge ref_clk);
		irq_pend <= 0;
		chk("wake mask", 0, stq[4][3]);
	endtask

	task automatic t_stop;
		int n;
		for (int k = 0; k < 2; k++) begin
			wr(8'h14, k);
			cmd(5'h1a, 0);
			chk("stop mask", 0, flags_and_mask[3]);
			chk("stop run", 0, cpu_run);
			@(posedge ref_clk);
			irq_pend <= 1;
			n = 0;
			@(negedge ref_clk);
			while (!stk_we) begin
				n++;
				@(negedge ref_clk);
			end
			chk("stop delay", 1, n >= (k ? 4 : 8) && n <= (k ? 8 : 12));
			vec(16'hfffa, 16'h5000);
			@(posedge ref_clk);
			irq_pend <= 0;
		end
	endtask

	initial begin
		#40000;
		bad_count++;
		end_sim;
	end

	initial begin
		t_reset;
		t_alu;
		t_stack;
		t_irq;
		t_break;
		t_wait;
		t_stop;
		end_sim;
	end
endmodule
